// >>> hw/sapq_top.sv
// pair sequencer of a single-engine 10-bit converter with an AXI4-Lite slave
// assumes triggers, idle and source ticks come from logic on aclk
`include "sapq_params.svh"
module sapq_top import sapq_pkg::*; #(
  parameter int NUM_PAIRS = 5,
  parameter int NUM_DED = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // system state and source clock ticks
  input wire logic idle_mode,
  input wire logic primary_tick,
  input wire logic aux_tick,
  // trigger pulses from pwm generators and timers
  input wire logic [13:0] trig_in,
  // approximation engine
  output sapq_conv_req_type conv_req,
  input wire sapq_conv_rsp_type conv_rsp,
  // sample-and-hold controls and pair interrupts
  output logic [NUM_DED-1:0] ded_sampling,
  output logic shared_sample,
  output logic [NUM_PAIRS-1:0] pair_irq
);
  localparam int CONV_CYC = (`SAPQ_CONV_NS * `SAPQ_CLK_KHZ + 999999) / 1000000;
  localparam int PW = $clog2(NUM_PAIRS);

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [15:0] ctrl_r;
  logic [NUM_PAIRS-1:0] ready_r, pend_r;
  logic [4*NUM_PAIRS-1:0] trig_sel_r;
  logic [15:0] res_r [`SAPQ_NUM_RES];
  sapq_state_type state_r;
  logic [PW-1:0] cur_r;
  logic second_r, gsw_d_r;
  logic [2:0] div_cnt_r;
  logic [7:0] space_r;
  logic [1:0] ded_cnt_r [NUM_DED];
  logic [NUM_DED-1:0] ded_held_r;
  logic shared_wait_r;
  logic [7:0] awaddr_r, araddr_r;
  logic aw_full_r, w_full_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  ////////////////////////////////////////////////////////////////////////
  // control decode
  wire converter_power_on = ctrl_r[`SAPQ_B_ON];
  wire run = converter_power_on & ~(ctrl_r[`SAPQ_B_SIDL] & idle_mode);
  wire result_justify_select = ctrl_r[`SAPQ_B_RESULT_JUSTIFY_SELECT];
  wire early_irq_select = ctrl_r[`SAPQ_B_EIE];
  wire order = ctrl_r[`SAPQ_B_ORDER];
  wire seqs = ctrl_r[`SAPQ_B_SEQ];
  wire async_s = ctrl_r[`SAPQ_B_ASYNC];
  wire [2:0] div = ctrl_r[`SAPQ_B_DIV_HI:`SAPQ_B_DIV_LO];
  wire src_tick = ctrl_r[`SAPQ_B_AUX] ? aux_tick : primary_tick;
  wire adc_tick = run & src_tick & (div_cnt_r == div);

  // triggers: code zero never fires, code one is the soft trigger edge
  wire gsw_pulse = ctrl_r[`SAPQ_B_GSW] & ~gsw_d_r;
  wire [15:0] trg_vec = {trig_in, gsw_pulse, 1'b0};
  logic [NUM_PAIRS-1:0] pair_trig;
  logic [PW-1:0] low_idx;
  always_comb begin
    low_idx = '0;
    for (int p = NUM_PAIRS - 1; p >= 0; p--) begin
      pair_trig[p] = run & trg_vec[trig_sel_r[4*p +: 4]];
      if (pend_r[p]) begin
        low_idx = PW'(p);
      end
    end
  end

  // channel of the current conversion
  wire phase_odd = second_r ^ order;
  wire is_ref = (cur_r == PW'(NUM_PAIRS - 1));
  wire [3:0] chan = is_ref ? (`SAPQ_REF_CHAN | 4'(phase_odd))
                           : {1'b0, 2'(cur_r), phase_odd};
  wire [3:0] res_idx = {3'(cur_r), phase_odd};
  wire [15:0] fmt = result_justify_select ? {conv_rsp.data, 6'h00} : {6'h00, conv_rsp.data};
  wire cur_ded = (cur_r < PW'(NUM_DED));
  wire ded_busy = cur_ded & ~async_s & (ded_cnt_r[cur_r[0]] != 2'h0);
  wire can_start = adc_tick & (space_r == 8'h00) & ~ded_busy;
  wire got = (state_r == ST_WAIT) & conv_rsp.done;
  wire fire_first = (state_r == ST_START) & can_start & ~second_r;
  wire fire_second = (state_r == ST_START) & can_start & second_r;
  wire shared_at_start = seqs ? (order ? fire_first : fire_second)
                              : (shared_wait_r & fire_first);

  ////////////////////////////////////////////////////////////////////////
  // conversion clock divider and start spacing
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_cnt_r <= 3'h0;
    end else if (src_tick) begin
      div_cnt_r <= (div_cnt_r == div) ? 3'h0 : div_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      space_r <= 8'h00;
    end else if (conv_req.start) begin
      space_r <= 8'(CONV_CYC - 2);
    end else if (space_r != 8'h00) begin
      space_r <= space_r - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pair sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || !converter_power_on) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      second_r <= 1'b0;
    end else if (run) begin
      unique case (state_r)
        ST_IDLE: begin
          if (|pend_r) begin
            cur_r <= low_idx;
            second_r <= 1'b0;
            state_r <= ST_START;
          end
        end
        ST_START: if (can_start) state_r <= ST_WAIT;
        ST_WAIT: begin
          if (conv_rsp.done) begin
            second_r <= 1'b1;
            state_r <= second_r ? ST_DONE : ST_START;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
      endcase
    end
  end
  // engine request and pair interrupts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_req <= '0;
      pair_irq <= '0;
      shared_sample <= 1'b0;
    end else begin
      conv_req.start <= (state_r == ST_START) & can_start;
      conv_req.chan <= chan;
      shared_sample <= shared_at_start | (run & ~seqs & (state_r == ST_IDLE) & |pair_trig);
      pair_irq <= '0;
      if (run && got && (second_r != early_irq_select)) begin
        pair_irq[cur_r] <= 1'b1;
      end
    end
  end
  // shared hold missed the trigger while busy, so it samples at the next first start
  always_ff @(posedge aclk) begin
    if (!aresetn || !converter_power_on) begin
      shared_wait_r <= 1'b0;
    end else if (run) begin
      if (|pair_trig && state_r != ST_IDLE) begin
        shared_wait_r <= 1'b1;
      end else if (fire_first) begin
        shared_wait_r <= 1'b0;
      end
    end
  end

  // dedicated holds, one per low pair
  for (genvar d = 0; d < NUM_DED; d++) begin : g_ded
    always_ff @(posedge aclk) begin
      if (!aresetn || !converter_power_on) begin
        ded_cnt_r[d] <= 2'h0;
        ded_held_r[d] <= 1'b0;
      end else if (pair_trig[d]) begin
        ded_held_r[d] <= 1'b1;
        ded_cnt_r[d] <= async_s ? 2'h0 : `SAPQ_SAMPLE_TICKS;
      end else begin
        if (adc_tick && ded_cnt_r[d] != 2'h0) begin
          ded_cnt_r[d] <= ded_cnt_r[d] - 2'h1;
        end
        if (state_r == ST_DONE && cur_r == PW'(d)) begin
          ded_held_r[d] <= 1'b0;
        end
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ded_sampling[d] <= 1'b0;
      end else begin
        ded_sampling[d] <= async_s ? (run & ~ded_held_r[d] & ~pair_trig[d])
                                   : (ded_cnt_r[d] != 2'h0) | (pair_trig[d] & run);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus write path
  wire do_wr = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wmd = wdata_r & wmask;
  wire wr_ctrl = do_wr & (awaddr_r == `SAPQ_ADDR_CTRL);
  wire wr_stat = do_wr & (awaddr_r == `SAPQ_ADDR_STAT);
  wire wr_trig = do_wr & (awaddr_r == `SAPQ_ADDR_TRIG);
  wire wr_pend = do_wr & (awaddr_r == `SAPQ_ADDR_PEND);
  wire wr_res = (awaddr_r >= `SAPQ_ADDR_RES0) &
                (awaddr_r < 8'(`SAPQ_ADDR_RES0 + 4 * `SAPQ_NUM_RES)) & (awaddr_r[1:0] == 2'h0);
  wire wr_ok = wr_ctrl | wr_stat | wr_trig | wr_pend | (do_wr & wr_res);
  wire [15:0] ctrl_m = converter_power_on ? `SAPQ_CTRL_LIVE : `SAPQ_CTRL_WMASK;
  wire [15:0] ctrl_wm = ctrl_m & wmask[15:0];
  wire [NUM_PAIRS-1:0] stat_clr = wmask[NUM_PAIRS-1:0] & ~wdata_r[NUM_PAIRS-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAPQ_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SAPQ_RESP_OKAY : `SAPQ_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready = ~w_full_r;

  // control, trigger select; soft trigger is left to software to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `SAPQ_CTRL_RST;
      trig_sel_r <= '0;
      gsw_d_r <= 1'b0;
    end else begin
      gsw_d_r <= ctrl_r[`SAPQ_B_GSW];
      if (wr_ctrl) begin
        ctrl_r <= (ctrl_r & ~ctrl_wm) | (wdata_r[15:0] & ctrl_wm);
      end
      if (wr_trig) begin
        trig_sel_r <= (trig_sel_r & ~wmask[4*NUM_PAIRS-1:0]) | wmd[4*NUM_PAIRS-1:0];
      end
    end
  end

  // ready and pending flags: hardware set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_r <= '0;
      pend_r <= '0;
    end else begin
      ready_r <= (ready_r & ~(wr_stat ? stat_clr : '0)) |
                 ((state_r == ST_DONE && run) ? (NUM_PAIRS'(1) << cur_r) : '0);
      if (!converter_power_on) begin
        pend_r <= '0;
      end else begin
        pend_r <= (pend_r & ~((state_r == ST_DONE && run) ? (NUM_PAIRS'(1) << cur_r) : '0))
                  | pair_trig | (wr_pend ? wmd[NUM_PAIRS-1:0] : '0);
      end
    end
  end

  // results, one per input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `SAPQ_NUM_RES; i++) begin
        res_r[i] <= 16'h0000;
      end
    end else if (run && got) begin
      res_r[res_idx] <= fmt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus read path
  wire [7:0] rel = araddr_r - `SAPQ_ADDR_RES0;
  wire rd_res = (araddr_r >= `SAPQ_ADDR_RES0) & (rel < 8'(4 * `SAPQ_NUM_RES)) & (rel[1:0] == 2'h0);
  logic [31:0] rd_data;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (araddr_r == `SAPQ_ADDR_CTRL) rd_data[15:0] = ctrl_r;
    else if (araddr_r == `SAPQ_ADDR_STAT) rd_data[NUM_PAIRS-1:0] = ready_r;
    else if (araddr_r == `SAPQ_ADDR_TRIG) rd_data[4*NUM_PAIRS-1:0] = trig_sel_r;
    else if (araddr_r == `SAPQ_ADDR_PEND) rd_data[NUM_PAIRS-1:0] = pend_r;
    else if (rd_res) rd_data[15:0] = res_r[rel[5:2]];
    else rd_ok = 1'b0;
  end
  logic ar_full_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_full_r <= 1'b0;
      araddr_r <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SAPQ_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_full_r <= 1'b1;
        araddr_r <= s_axi_araddr;
      end else if (ar_full_r && !s_axi_rvalid) begin
        ar_full_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? `SAPQ_RESP_OKAY : `SAPQ_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = ~ar_full_r & ~s_axi_rvalid;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_spacing;
    conv_req.start |=> !conv_req.start [*8];
  endproperty
  a_spacing: assert property (p_spacing) else $error("conversion starts too close");
  property p_lowest;
    state_r == ST_IDLE && run && |pend_r |=> cur_r == $past(low_idx) && state_r == ST_START;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest pending pair not taken");
  property p_off;
    !converter_power_on |=> state_r == ST_IDLE && pend_r == '0;
  endproperty
  a_off: assert property (p_off) else $error("converter active while off");
  property p_halt;
    converter_power_on && !run |=> $stable(state_r) && $stable(cur_r);
  endproperty
  a_halt: assert property (p_halt) else $error("sequencer moved while halted");
  property p_format;
    run && got && result_justify_select |=> res_r[$past(res_idx)][5:0] == 6'h00;
  endproperty
  a_format: assert property (p_format) else $error("left-justified result has low bits");
  property p_early;
    run && got && !second_r && early_irq_select |=> pair_irq[$past(cur_r)];
  endproperty
  a_early: assert property (p_early) else $error("early interrupt missing");
  property p_order;
    conv_req.start |-> conv_req.chan[0] == ($past(second_r) ^ $past(order));
  endproperty
  a_order: assert property (p_order) else $error("wrong input converted first");
  property p_seq_shared;
    seqs && converter_power_on && $past(seqs) && shared_sample |-> conv_req.start;
  endproperty
  a_seq_shared: assert property (p_seq_shared) else $error("shared hold off its slot");
  property p_ready_src;
    $rose(ready_r[0]) |-> $past(state_r) == ST_DONE && $past(cur_r) == '0;
  endproperty
  a_ready_src: assert property (p_ready_src) else $error("ready set without completion");
  property p_lock;
    converter_power_on && $past(converter_power_on) |-> (ctrl_r & ~`SAPQ_CTRL_LIVE) == ($past(ctrl_r) & ~`SAPQ_CTRL_LIVE);
  endproperty
  a_lock: assert property (p_lock) else $error("configuration changed while on");

  c_pair: cover property (state_r == ST_DONE ##1 state_r == ST_IDLE);
  c_two_pend: cover property (run && pend_r[0] && pend_r[1] && state_r == ST_IDLE);
  c_gsw: cover property (gsw_pulse && |pair_trig);
  c_clr_race: cover property (wr_stat && state_r == ST_DONE);
endmodule

// >>> hw/sapq_params.svh
// constants of the pair sequencer: register map, fields, resets, timing
// assumes a 32-bit register bus where each register takes one aligned word
// Function
// - one conversion at a time; starts spaced for at most two million per second
// - at most three held inputs: two dedicated holds plus one shared hold
// - several pending pairs are served in turn, lowest pair first
// - each pair picks its own trigger out of sixteen sources
// - each dedicated hold is triggered independently of the others
// - reference pair converts channels twelve and thirteen
// - power-on bit fifteen enables the converter, clearing it turns it off
// - idle-stop bit halts the converter while the device idles
// - clock-select bit picks auxiliary source when set, primary when clear
// - global soft trigger fires selecting pairs; software clears it, hardware never
// - format bit: set left-justifies result, clear right-justifies it
// - early bit: pair interrupt after first conversion, else after second
// - order bit: odd input first when set, even input first when clear
// - sequential: shared hold samples at second start, or first if odd-first
// - not sequential: shared samples with trigger if idle, else at next first start
// - free-run: dedicated hold samples constantly, stops at its trigger
// - not free-run: dedicated hold samples two converter ticks after trigger
// - divider field divides source by value plus one, reset divide-by-four
// - configuration fields change only while converter is off
// - ready flag set by hardware at data ready, cleared by writing zero
// - pending flag set by trigger, held until the pair completes
`ifndef SAPQ_PARAMS_SVH
`define SAPQ_PARAMS_SVH
// register byte offsets
`define SAPQ_ADDR_CTRL 8'h00
`define SAPQ_ADDR_STAT 8'h04
`define SAPQ_ADDR_TRIG 8'h08
`define SAPQ_ADDR_PEND 8'h0C
`define SAPQ_ADDR_RES0 8'h10
`define SAPQ_NUM_RES 10
// control register fields
`define SAPQ_B_ON 15
`define SAPQ_B_SIDL 13
`define SAPQ_B_AUX 12
`define SAPQ_B_GSW 10
`define SAPQ_B_RESULT_JUSTIFY_SELECT 8
`define SAPQ_B_EIE 7
`define SAPQ_B_ORDER 6
`define SAPQ_B_SEQ 5
`define SAPQ_B_ASYNC 4
`define SAPQ_B_DIV_HI 2
`define SAPQ_B_DIV_LO 0
`define SAPQ_CTRL_RST 16'h0003
`define SAPQ_CTRL_WMASK 16'hB5F7
`define SAPQ_CTRL_LIVE 16'hA400
// channel numbers of the reference pair
`define SAPQ_REF_CHAN 4'hC
// trigger selector codes: zero never fires, one is the global soft trigger
`define SAPQ_TRG_GSW 4'h1
// sampling and conversion timing
`define SAPQ_SAMPLE_TICKS 2'h2
`define SAPQ_CONV_NS 500
`define SAPQ_CLK_KHZ 20000
// bus responses
`define SAPQ_RESP_OKAY 2'h0
`define SAPQ_RESP_SLVERR 2'h2
`endif

// >>> hw/sapq_pkg.sv
// types of the pair sequencer
// assumes sapq_params.svh for the figures
package sapq_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } sapq_state_type;
  // request to the approximation engine
  typedef struct packed {
    logic start;
    logic [3:0] chan;
  } sapq_conv_req_type;
  // answer from the approximation engine
  typedef struct packed {
    logic done;
    logic [9:0] data;
  } sapq_conv_rsp_type;
endpackage

// >>> verification/sapq_far_model.sv
// far-side model: trigger sources and the approximation engine
// assumes pulses and requests on aclk, reset synchronous active low
module sapq_far_model import sapq_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench controls
  input wire logic [13:0] fire,
  input wire logic [3:0] lat,
  input wire logic [139:0] vals,
  // triggers and engine link
  output logic [13:0] trig_in,
  input wire sapq_conv_req_type conv_req,
  output sapq_conv_rsp_type conv_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_r;
  logic [3:0] cnt_r;
  logic [3:0] chan_r;
  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle triggers; engine answers lat plus two cycles after start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_in <= 14'h0000;
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      chan_r <= 4'h0;
      conv_rsp <= '0;
    end else begin
      trig_in <= fire;
      conv_rsp.done <= 1'b0;
      conv_rsp.data <= ~conv_rsp.data; // no stale value outside done
      if (conv_req.start) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
        chan_r <= conv_req.chan;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        conv_rsp.done <= 1'b1;
        conv_rsp.data <= vals[int'(chan_r) * 10 +: 10];
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// >>> verification/tb.sv
// self-checking bench of the pair sequencer over its register bus
// assumes sapq_far_model for triggers and the engine answer
`include "sapq_params.svh"
module tb import sapq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic idle_mode = 1'b0, primary_tick = 1'b0, aux_tick = 1'b0;
  logic [13:0] trig_in;
  logic [13:0] fire = 14'h0000;
  logic [3:0] lat = 4'h0;
  logic [139:0] vals = '0;
  logic [16:0] seed;
  sapq_conv_req_type conv_req;
  sapq_conv_rsp_type conv_rsp;
  logic [1:0] ded_sampling;
  logic shared_sample;
  logic [4:0] pair_irq;
  logic [33:0] bus_q[$];
  logic [3:0] chan_q[$];
  int n_errors = 0;
  int n_tests = 0;
  int n_shared = 0;
  int sh0 = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock and source ticks
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    primary_tick <= ~primary_tick;
    aux_tick <= ~aux_tick & ~primary_tick;
  end
  sapq_top u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .idle_mode,
    .primary_tick, .aux_tick, .trig_in, .conv_req, .conv_rsp, .ded_sampling,
    .shared_sample, .pair_irq);
  sapq_far_model u_far (.aclk, .aresetn, .fire, .lat, .vals, .trig_in, .conv_req,
    .conv_rsp);
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic logic [33:0] res_exp(input int i, input bit left);
    logic [9:0] d;
    d = vals[10 * (i < 8 ? i : i + 4) +: 10];
    return left ? {18'h0, d, 6'h00} : {24'h0, d};
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_errors++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bus write: release each channel when taken, hold bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_t, w_t, hs;
    bus_q.push_back({er, 32'h0});
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    hs = 0;
    for (int n = 0; n < 200 && !hs; n++) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      hs = s_axi_bvalid & s_axi_bready;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!hs) n_errors++;
  endtask
  // bus read: expected word noted for the watcher
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    bit ar_t, hs;
    bus_q.push_back(exp);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    hs = 0;
    for (int n = 0; n < 200 && !hs; n++) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid & s_axi_arready;
      hs = s_axi_rvalid & s_axi_rready;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!hs) n_errors++;
  endtask
  task automatic fire_trig(input logic [13:0] m);
    @(posedge aclk);
    fire <= m;
    @(posedge aclk);
    fire <= 14'h0000;
  endtask
  task automatic wait_irq(input int p);
    bit got;
    got = 0;
    for (int n = 0; n < 600 && !got; n++) begin
      @(negedge aclk);
      got = pair_irq[p];
    end
    check({33'h0, got}, 34'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watcher: bus answers and engine starts against the oldest note
  always @(negedge aclk) begin
    if (shared_sample) n_shared++;
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, bus_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, bus_q.pop_front());
    if (conv_req.start) check({30'h0, conv_req.chan},
      {30'h0, (chan_q.size() > 0) ? chan_q.pop_front() : 4'hX});
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    $display("watchdog expired");
    n_errors++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 17'h114BF;
    for (int c = 0; c < 14; c++) begin
      seed = lfsr_next(seed);
      vals[c * 10 +: 10] = seed[9:0];
    end
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SAPQ_ADDR_CTRL, 34'h0_0000_0003);
    rd(`SAPQ_ADDR_STAT, 34'h0);
    rd(8'h40, {`SAPQ_RESP_SLVERR, 32'h0});
    wr(8'h40, 32'hFFFF_FFFF, `SAPQ_RESP_SLVERR);
    $display("test reset done");
    wr(`SAPQ_ADDR_TRIG, 32'h0001_0032, `SAPQ_RESP_OKAY);
    rd(`SAPQ_ADDR_TRIG, 34'h0_0001_0032);
    wr(`SAPQ_ADDR_CTRL, 32'h0000_0002, `SAPQ_RESP_OKAY);
    wr(`SAPQ_ADDR_CTRL, 32'h0000_8002, `SAPQ_RESP_OKAY);
    wr(`SAPQ_ADDR_CTRL, 32'h0000_81C7, `SAPQ_RESP_OKAY);
    rd(`SAPQ_ADDR_CTRL, 34'h0_0000_8002);
    $display("test config lock done");
    chan_q = '{4'h0, 4'h1, 4'h2, 4'h3};
    lat <= 4'h2;
    fire_trig(14'h0003);
    wait_irq(1);
    rd(`SAPQ_ADDR_STAT, 34'h0_0000_0003);
    for (int i = 0; i < 4; i++) rd(`SAPQ_ADDR_RES0 + 8'(4 * i), res_exp(i, 0));
    wr(`SAPQ_ADDR_STAT, 32'h0, `SAPQ_RESP_OKAY);
    rd(`SAPQ_ADDR_STAT, 34'h0);
    $display("test two pairs done");
    wr(`SAPQ_ADDR_CTRL, 32'h0000_A002, `SAPQ_RESP_OKAY);
    @(posedge aclk);
    idle_mode <= 1'b1;
    fire_trig(14'h0001);
    repeat (4) @(posedge aclk);
    rd(`SAPQ_ADDR_PEND, 34'h0);
    wr(`SAPQ_ADDR_PEND, 32'h0000_0001, `SAPQ_RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(`SAPQ_ADDR_PEND, 34'h0_0000_0001);
    chan_q = '{4'h0, 4'h1};
    @(posedge aclk);
    idle_mode <= 1'b0;
    wait_irq(0);
    rd(`SAPQ_ADDR_PEND, 34'h0);
    $display("test idle stop done");
    wr(`SAPQ_ADDR_CTRL, 32'h0000_0002, `SAPQ_RESP_OKAY);
    wr(`SAPQ_ADDR_CTRL, 32'h0000_0142, `SAPQ_RESP_OKAY);
    wr(`SAPQ_ADDR_CTRL, 32'h0000_8142, `SAPQ_RESP_OKAY);
    lat <= 4'hC;
    chan_q = '{4'hD, 4'hC};
    wr(`SAPQ_ADDR_CTRL, 32'h0000_8542, `SAPQ_RESP_OKAY);
    wait_irq(4);
    rd(`SAPQ_ADDR_CTRL, 34'h0_0000_8542);
    for (int i = 8; i < 10; i++) rd(`SAPQ_ADDR_RES0 + 8'(4 * i), res_exp(i, 1));
    chan_q = '{4'h3, 4'h2};
    fire_trig(14'h0002);
    wait_irq(1);
    for (int i = 2; i < 4; i++) rd(`SAPQ_ADDR_RES0 + 8'(4 * i), res_exp(i, 1));
    $display("test odd first done");
    wr(`SAPQ_ADDR_CTRL, 32'h0000_8142, `SAPQ_RESP_OKAY);
    chan_q = '{4'hD, 4'hC};
    wr(`SAPQ_ADDR_CTRL, 32'h0000_8542, `SAPQ_RESP_OKAY);
    wait_irq(4);
    $display("test soft trigger again done");
    wr(`SAPQ_ADDR_CTRL, 32'h0000_0000, `SAPQ_RESP_OKAY);
    wr(`SAPQ_ADDR_STAT, 32'h0, `SAPQ_RESP_OKAY);
    wr(`SAPQ_ADDR_CTRL, 32'h0000_10B0, `SAPQ_RESP_OKAY);
    wr(`SAPQ_ADDR_CTRL, 32'h0000_90B0, `SAPQ_RESP_OKAY);
    @(negedge aclk);
    check(34'(ded_sampling), 34'h3);
    chan_q = '{4'h0, 4'h1};
    sh0 = n_shared;
    fire_trig(14'h0001);
    wait_irq(0);
    check(34'(chan_q.size()), 34'h1);
    check(34'(ded_sampling), 34'h2);
    repeat (80) @(negedge aclk);
    check(34'(n_shared - sh0), 34'h1);
    check(34'(ded_sampling), 34'h3);
    rd(`SAPQ_ADDR_STAT, 34'h0_0000_0001);
    $display("test free run early done");
    give_verdict;
  end
endmodule
